// [bench/scp_spi_host.sv]
// Purpose: serial controller model for the shared pins of the switch port
// Assumes: clock mode 0 or 3; outside frames the link clock moves only to reach its idle level
// Notes: nclk below 16 cuts a frame short on purpose
`timescale 1ns/1ps
`default_nettype none
module scp_spi_host (
  output logic sdi,
  output logic cs_n,
  output logic sclk,
  input wire logic sdo
);
  localparam realtime HALF = 62.5; // 125 ns period stays under 10 MHz
  initial begin
    sdi = 1'b0;
    cs_n = 1'b1;
    sclk = 1'b0;
  end
  // data changes on falls; both sides sample on rises
  task automatic frame(input bit mode3, input logic [15:0] cmd, input int nclk,
    output logic [15:0] rx);
    rx = 16'h0000;
    sclk = mode3; // idle level selects mode 0 or mode 3
    #HALF;
    cs_n = 1'b0; // low for the whole frame
    for (int i = 0; i < nclk; i++) begin // 16 cycles in a full frame
      #HALF;
      sclk = 1'b0;
      sdi = (i < 16) ? cmd[15 - i] : 1'b0; // msb first
      #HALF;
      sclk = 1'b1;
      rx = {rx[14:0], sdo}; // data out read on the rise
    end
    #HALF;
    sclk = mode3;
    #HALF;
    cs_n = 1'b1;
    #150; // select high time between frames
  endtask
endmodule // scp_spi_host
`default_nettype wire

// [bench/scp_switch_ctrl_bench.sv]
// Purpose: self-checking bench for the switch control port
// Assumes: the controller model drives the shared pins in serial mode
// Notes: random levels and commands come from an lfsr with a fixed start
`timescale 1ns/1ps
`default_nettype none
module scp_switch_ctrl_bench;
  import scp_pkg::*;
  logic clk, resetn, sel, last4, psel, penable, pwrite, pready, pslverr, sdi, cs_n, sclk;
  logic pin4_out, pin4_oe_n, wire4, err;
  logic [3:0] par, switch_on, sw;
  logic [7:0] paddr;
  logic [15:0] rx;
  logic [31:0] pwdata, prdata, rd, seed;
  int fails, checked, cyc;
  scp_pins_t pins;
  // a released data line floats, so show the inverse of its last level
  assign wire4 = !pin4_oe_n ? pin4_out : (sel ? ~last4 : par[3]);
  assign pins = '{iface_sel: sel, pin4: wire4, pin3: sel ? sclk : par[2],
    pin2: sel ? cs_n : par[1], pin1: sel ? sdi : par[0]};
  scp_switch_ctrl dut_u (.clk(clk), .resetn(resetn), .pins(pins), .pin4_out(pin4_out),
    .pin4_oe_n(pin4_oe_n), .switch_on(switch_on), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  scp_spi_host host_u (.sdi(sdi), .cs_n(cs_n), .sclk(sclk), .sdo(wire4));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // track the driven level and cut a hung run short
  always @(posedge clk) begin
    if (!pin4_oe_n) last4 <= pin4_out;
    cyc = cyc + 1;
    if (cyc == 60000) begin
      fails++;
      summarize();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // read frame: alignment byte, then four zero bits and the four switch bits
  function automatic logic [15:0] rd_exp(input logic [3:0] s);
    return {8'h25, 4'h0, s};
  endfunction
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one bus transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no limit of its own: the run's cycle ceiling ends a hung wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    chk("pready", 32'h1, {31'h0, pready});
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic spi(input bit m3, input logic [15:0] c, input int n);
    host_u.frame(m3, c, n, rx);
  endtask
  task automatic wsw(input logic [3:0] e);
    int n;
    n = 0;
    while (switch_on !== e && n < 30) begin
      @(posedge clk);
      n++;
    end
    chk("switch_on", {28'h0, e}, {28'h0, switch_on});
  endtask
  task automatic summarize();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    resetn = 1'b0;
    sel = 1'b0;
    par = 4'h0;
    last4 = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    seed = 32'h821e_7fff;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    // parallel mode with random levels
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      @(posedge clk);
      par <= seed[3:0];
      wsw(seed[3:0]);
      chk("oe_n", 32'h1, {31'h0, pin4_oe_n});
    end
    // serial mode after the start-up wait, modes 0 and 3 in turn
    @(posedge clk);
    sel <= 1'b1;
    #10000;
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      sw = seed[3:0];
      spi(i[0], {1'b0, 7'h01, seed[7:0]}, 16);
      wsw(sw);
      spi(!i[0], {1'b1, 7'h01, seed[15:8]}, 16);
      chk("sdo", {16'h0, rd_exp(sw)}, {16'h0, rx});
      chk("oe_n", 32'h1, {31'h0, pin4_oe_n});
    end
    // seventeen clocks: the extra rise is not counted
    sw = ~sw;
    spi(1'b0, {1'b0, 7'h01, 4'h0, sw}, 17);
    wsw(sw);
    // short frames and a foreign address leave the switches alone
    spi(1'b0, {1'b0, 7'h01, 4'h0, ~sw}, 15);
    spi(1'b1, {1'b0, 7'h01, 4'h0, ~sw}, 8);
    spi(1'b0, {1'b0, 7'h02, 4'h0, ~sw}, 16);
    chk("sw_kept", {28'h0, sw}, {28'h0, switch_on});
    // bus side: read-only and unmapped places, then the shared register
    apb(1'b1, 8'h08, 32'hffff_ffff, rd, err);
    apb(1'b0, 8'h08, 32'h0, rd, err);
    chk("lastcmd", {16'h0, 1'b0, 7'h02, 4'h0, ~sw}, rd);
    chk("rd_ok", 32'h0, {31'h0, err});
    apb(1'b0, 8'h0c, 32'h0, rd, err);
    chk("slverr", 32'h1, {31'h0, err});
    apb(1'b1, 8'h04, 32'h0000_0005, rd, err);
    wsw(4'h5);
    apb(1'b0, 8'h00, 32'h0, rd, err);
    chk("status", 32'h15, rd & 32'h0000_001f);
    spi(1'b0, 16'h8200, 16);
    chk("sdo_other", 32'h0000_2500, {16'h0, rx});
    spi(1'b1, 16'h8100, 16);
    chk("sdo", {16'h0, rd_exp(4'h5)}, {16'h0, rx});
    // back to parallel, then a reset in mid-run
    @(posedge clk);
    sel <= 1'b0;
    par <= 4'ha;
    wsw(4'ha);
    @(posedge clk);
    resetn <= 1'b0;
    sel <= 1'b1;
    @(posedge clk);
    chk("sw_in_reset", 32'h0, {28'h0, switch_on});
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    apb(1'b0, 8'h04, 32'h0, rd, err);
    chk("sw_after_reset", 32'h0, rd);
    summarize();
  end
endmodule // scp_switch_ctrl_bench
`default_nettype wire

// [inc/scp_pkg.sv]
// Purpose: types of the switch control port
// Assumes: scp_regs.svh carries all numbers
// Notes: pin carrier order is fixed, bit 0 is shared pin 1
`default_nettype none
package scp_pkg;
  // shared pins as seen by the block, raw from the board
  typedef struct packed {
    logic iface_sel;
    logic pin4;
    logic pin3;
    logic pin2;
    logic pin1;
  } scp_pins_t;
  // progress of one addressable frame
  typedef enum logic [1:0] {
    SCP_PH_IDLE,
    SCP_PH_ADDR,
    SCP_PH_DATA,
    SCP_PH_DONE
  } scp_phase_t;
endpackage
`default_nettype wire

// [inc/scp_regs.svh]
// Purpose: constants of the switch control port (offsets, layouts, resets, counts)
// Assumes: APB byte addresses, 32-bit data, one aligned word per register
// Notes: definitions only
// Summary of operation
// [R1] interface select low: switches follow the parallel inputs, serial traffic ignored
// [R2] parallel input one closes its channel, zero opens it, each independently
// [R3] ctrl_1 port_1a, ctrl_2 port_2a, ctrl_3 port_2b, ctrl_4 port_1b
// [R4] interface select high: serial interface controls switches and registers
// [R5] serial clock mode 0 or 3; controller keeps clock at most 10 MHz
// [R6] serial side starts in addressable mode after power-up
// [R7] a frame spans chip select low to high with exactly 16 clocks
// [R8] controller holds chip select low for the whole transaction
// [R9] data in sampled on rising clock, data out changed on falling clock
// [R10] data out is push-pull and released whenever not driven
// [R11] command is msb first: read/write flag, seven address bits, eight data
// [R12] target address latched on the eighth rising clock edge
// [R13] write updates the addressed register on the sixteenth rising edge
// [R14] read ignores the last eight input bits and shifts register data out
// [R15] read data driven from the eighth to the fifteenth falling edge
// [R16] mode 0 sends alignment 0x25 at select fall and first seven falling edges
// [R17] mode 3 ignores the first falling edge for alignment timing
// [R18] controller waits at least 10 us after reset before any command
// [R19] only a hardware reset returns the logic to its initial state
// [R20] read/write flag one means read, zero means write
// [R21] select rising before the sixteenth clock discards the command
`ifndef SCP_REGS_SVH
`define SCP_REGS_SVH
`define SCP_APB_STATUS 8'h00
`define SCP_APB_SWITCH 8'h04
`define SCP_APB_LASTCMD 8'h08
`define SCP_SPI_SW_ADDR 7'h01
`define SCP_ALIGN 8'h25
`define SCP_FRAME_BITS 5'd16
`define SCP_ADDR_BITS 5'd8
`define SCP_SW_RESET 4'h0
`define SCP_CMD_RESET 16'h0000
`define SCP_RD_FLAG 1'b1
`endif

// [rtl/scp_switch_ctrl.sv]
// Purpose: digital front end of a four-channel switch, parallel or serial control
// Assumes: pins from outside the clk domain; serial clock far below clk
// Notes: APB slave answers with one wait state; serial registers at own addresses
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "scp_regs.svh"
module scp_switch_ctrl
  import scp_pkg::*;
#(
  parameter int SYNC_STAGES = 3
) (
  input wire logic clk,
  input wire logic resetn,
  input wire scp_pins_t pins,
  output logic pin4_out,
  output logic pin4_oe_n,
  output logic [3:0] switch_on,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // the glitch filter needs two stages behind the first one
  if (SYNC_STAGES < 3) begin : g_chk
    $error("SYNC_STAGES must be at least 3");
  end

  localparam int NPIN = 5;
  // alignment byte as a sized constant, so that single bits can be picked
  localparam logic [7:0] ALIGN = `SCP_ALIGN;

  logic [NPIN-1:0] pin_raw;
  logic [SYNC_STAGES-1:0] sync_q [NPIN];
  logic [NPIN-1:0] filt;
  logic sclk_d;
  logic cs_d;
  logic [4:0] rcnt;
  logic [15:0] shreg;
  logic cmd_rw;
  logic [6:0] cmd_addr;
  logic [7:0] out_sh;
  logic [3:0] sw_reg;
  logic [15:0] last_cmd;
  scp_phase_t phase;

  assign pin_raw = pins;

  // three-stage synchronisers; a level counts once the last two agree
  for (genvar i = 0; i < NPIN; i++) begin : g_sync
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        sync_q[i] <= '0;
        filt[i] <= 1'b0;
      end else begin
        sync_q[i] <= {sync_q[i][SYNC_STAGES-2:0], pin_raw[i]};
        if (sync_q[i][SYNC_STAGES-1] == sync_q[i][SYNC_STAGES-2]) begin
          filt[i] <= sync_q[i][SYNC_STAGES-1];
        end
      end
    end
  end

  // filtered pin meanings in serial mode
  logic f_sdi;
  logic f_cs_n;
  logic f_sclk;
  logic spi_act;
  assign f_sdi = filt[0];
  assign f_cs_n = filt[1];
  assign f_sclk = filt[2];
  assign spi_act = filt[4]; // R4

  // edge finders on filtered levels; serial logic is dead in parallel mode
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic in_frame;
  assign in_frame = spi_act && !f_cs_n; // R1
  assign sclk_rise = in_frame && f_sclk && !sclk_d; // R9
  assign sclk_fall = in_frame && !f_sclk && sclk_d; // R9
  assign cs_fall = spi_act && !f_cs_n && cs_d;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclk_d <= 1'b0;
      cs_d <= 1'b1;
    end else begin
      sclk_d <= f_sclk;
      cs_d <= f_cs_n;
    end
  end

  // register contents as seen by a serial read; status bits 7:6 never flag
  function automatic logic [7:0] spi_read(input logic [6:0] a, input logic [3:0] sw);
    spi_read = (a == `SCP_SPI_SW_ADDR) ? {4'h0, sw} : 8'h00;
  endfunction

  // write strobes from both sides, and the APB access strobe
  logic spi_wr;
  logic apb_wr;
  logic apb_rd;
  assign spi_wr = sclk_rise && (rcnt == `SCP_FRAME_BITS - 5'd1) &&
                  (cmd_rw != `SCP_RD_FLAG) && (cmd_addr == `SCP_SPI_SW_ADDR);
  assign apb_wr = psel && penable && pready && pwrite && !pslverr;
  assign apb_rd = psel && penable && !pready;

  // input shifter and edge counter; only 16 rising edges count in a frame
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rcnt <= 5'd0;
      shreg <= `SCP_CMD_RESET;
    end else if (cs_fall) begin
      rcnt <= 5'd0; // R7
      shreg <= `SCP_CMD_RESET;
    end else if (sclk_rise && rcnt < `SCP_FRAME_BITS) begin
      shreg <= {shreg[14:0], f_sdi}; // R11
      rcnt <= rcnt + 5'd1; // R7
    end
  end

  // command header caught on the eighth rising edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmd_rw <= 1'b0;
      cmd_addr <= 7'h00;
    end else if (sclk_rise && rcnt == `SCP_ADDR_BITS - 5'd1) begin
      cmd_rw <= shreg[6]; // R20
      cmd_addr <= {shreg[5:0], f_sdi}; // R12
    end
  end

  // frame phase, kept for status; a short frame just returns to idle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase <= SCP_PH_IDLE; // R6
    end else if (!in_frame) begin
      phase <= SCP_PH_IDLE; // R21
    end else if (cs_fall) begin
      phase <= SCP_PH_ADDR;
    end else if (sclk_rise && rcnt == `SCP_ADDR_BITS - 5'd1) begin
      phase <= SCP_PH_DATA;
    end else if (sclk_rise && rcnt == `SCP_FRAME_BITS - 5'd1) begin
      phase <= SCP_PH_DONE;
    end
  end

  // switch data register; a serial write wins over an APB write in one cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sw_reg <= `SCP_SW_RESET; // R19
    end else if (spi_wr) begin
      sw_reg <= {shreg[2:0], f_sdi}; // R13
    end else if (apb_wr && paddr == `SCP_APB_SWITCH) begin
      sw_reg <= pwdata[3:0];
    end
  end

  // last complete command, for software; partial frames never land here
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      last_cmd <= `SCP_CMD_RESET;
    end else if (sclk_rise && rcnt == `SCP_FRAME_BITS - 5'd1) begin
      last_cmd <= {shreg[14:0], f_sdi}; // R21
    end
  end

  // output shifter: alignment first, then read data; the first fall with no
  // rising edge before it belongs to mode 3 and is skipped
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_sh <= 8'h00;
      pin4_out <= 1'b0;
    end else if (!in_frame) begin
      out_sh <= 8'h00;
      pin4_out <= 1'b0;
    end else if (cs_fall) begin
      pin4_out <= ALIGN[7]; // R16
      out_sh <= {ALIGN[6:0], 1'b0};
    end else if (sclk_rise && rcnt == `SCP_ADDR_BITS - 5'd1) begin
      // read data replaces what is left of the alignment byte
      out_sh <= (shreg[6] == `SCP_RD_FLAG) ?
                spi_read({shreg[5:0], f_sdi}, sw_reg) : 8'h00; // R14
    end else if (sclk_fall && rcnt != 5'd0 && rcnt < `SCP_FRAME_BITS) begin
      pin4_out <= out_sh[7]; // R15 R17 R5
      out_sh <= {out_sh[6:0], 1'b0};
    end
  end

  // data out is driven only inside a serial frame
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin4_oe_n <= 1'b1;
    end else begin
      pin4_oe_n <= !in_frame; // R10
    end
  end

  // channel drive: parallel pins map one to one onto the channels
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      switch_on <= `SCP_SW_RESET;
    end else if (spi_act) begin
      switch_on <= sw_reg; // R4
    end else begin
      switch_on <= filt[3:0]; // R1 R2 R3
    end
  end

  // APB: one wait state so that read data leaves a flip-flop
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (apb_rd) begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      unique case (paddr)
        `SCP_APB_STATUS: prdata <= {25'h0, phase, spi_act, switch_on};
        `SCP_APB_SWITCH: prdata <= {28'h0, sw_reg};
        `SCP_APB_LASTCMD: prdata <= {16'h0, last_cmd};
        default: begin
          prdata <= 32'h0000_0000;
          pslverr <= 1'b1;
        end
      endcase
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_par_follow: assert property (!spi_act |=> switch_on == $past(filt[3:0])) // R1 R2 R3
    else $error("parallel channels do not follow pins");

  a_spi_drive: assert property (spi_act |=> switch_on == $past(sw_reg)) // R4
    else $error("serial mode channels differ from register");

  a_addr_latch: assert property (sclk_rise && rcnt == 5'd7 |=>
                                 cmd_addr == $past({shreg[5:0], f_sdi})) // R12
    else $error("address not caught on eighth rising edge");

  a_write_edge: assert property (spi_wr |=> sw_reg == $past({shreg[2:0], f_sdi})) // R13
    else $error("write missed on sixteenth rising edge");

  a_no_partial: assert property (!spi_wr && !apb_wr |=> $stable(sw_reg)) // R21 R14
    else $error("register changed without a full write");

  a_align_start: assert property (cs_fall |=> pin4_out == 1'b0 && !pin4_oe_n ##0
                                  out_sh == 8'h4a) // R16
    else $error("alignment byte not started");

  a_sdo_release: assert property (!in_frame |=> pin4_oe_n && !pin4_out) // R10
    else $error("data out driven outside a frame");

  a_mode3_skip: assert property (sclk_fall && rcnt == 5'd0 && !cs_fall |=>
                                 $stable(pin4_out) && $stable(out_sh)) // R17
    else $error("first falling edge not ignored");

  a_read_bit: assert property (sclk_fall && rcnt == 5'd8 && cmd_rw == `SCP_RD_FLAG |=>
                               pin4_out == $past(out_sh[7])) // R15
    else $error("first read bit wrong");

  a_read_load: assert property (sclk_rise && rcnt == 5'd7 && shreg[6] == `SCP_RD_FLAG |=>
                                out_sh == ((cmd_addr == `SCP_SPI_SW_ADDR) ?
                                           {4'h0, $past(sw_reg)} : 8'h00)) // R14
    else $error("read data not loaded on eighth rising edge");

  a_late_rise: assert property (sclk_rise && rcnt == `SCP_FRAME_BITS && !cs_fall |=>
                                rcnt == `SCP_FRAME_BITS && $stable(last_cmd)) // R7
    else $error("rise beyond the sixteenth was counted");

  a_lastcmd_hold: assert property (!(sclk_rise && rcnt == `SCP_FRAME_BITS - 5'd1) |=>
                                   $stable(last_cmd)) // R21
    else $error("command log changed without a full frame");

  a_oe_frame: assert property (in_frame |=> !pin4_oe_n) // R10
    else $error("data out not driven inside a frame");

  a_par_quiet: assert property (!spi_act |=> pin4_oe_n && phase == SCP_PH_IDLE) // R1
    else $error("serial side active in parallel mode");

  a_phase_idle: assert property (!in_frame |=> phase == SCP_PH_IDLE) // R21
    else $error("frame phase kept after select rose");

  a_apb_err: assert property (apb_rd && paddr != `SCP_APB_STATUS &&
                              paddr != `SCP_APB_SWITCH && paddr != `SCP_APB_LASTCMD |=>
                              pslverr && prdata == 32'h0000_0000)
    else $error("unmapped bus access not refused");

  a_apb_answer: assert property (apb_rd |=> pready ##1 !pready)
    else $error("APB answer not one cycle late");

endmodule // scp_switch_ctrl
`default_nettype wire
